// File: dv/pin_drive.sv
// Model of the external sources on the pins of ports 0 and 1.
// Assumes the bench sets the external levels; pulls are taken as pull-up.
`timescale 1ns/1ps
module pin_drive (
  input wire logic clk,
  input wire logic slow,
  input wire logic [7:0] ext0,
  input wire logic [7:0] ext1,
  input wire logic [7:0] drv1,
  input wire gpio_des_pkg::pad_ctrl_s pad,
  output logic [7:0] pin0,
  output logic [7:0] pin1
);
  logic [7:0] q0 = 8'h00;
  logic [7:0] q1 = 8'h00;
  logic [7:0] tog = 8'h55;
  logic [7:0] src1;

  // ----------------------------------------------------------------
  // Source timing
  // ----------------------------------------------------------------
  // A slow source shows new levels one cycle late; floating bits toggle
  always_ff @(posedge clk) begin
    q0 <= ext0;
    q1 <= ext1;
    tog <= ~tog;
  end

  assign src1 = slow ? q1 : ext1;
  assign pin0 = slow ? q0 : ext0;

  // ----------------------------------------------------------------
  // Pin resolution
  // ----------------------------------------------------------------
  // Pad driver first, then the external source, then the pull, else floating
  assign pin1 = (pad.out_en & pad.out_val) | (~pad.out_en & drv1 & src1) |
    (~pad.out_en & ~drv1 & pad.pull_en) | (~pad.out_en & ~drv1 & ~pad.pull_en & tog);
endmodule : pin_drive

// File: dv/tb.sv
// Self-checking bench for the GPIO direction and edge-select block.
// Assumes the pin model in pin_drive.sv and a 200 MHz system clock.
`timescale 1ns/1ps
module tb;
  import gpio_des_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rsp;
  logic [31:0] rdata, v, d;
  logic [7:0] ext0 = 8'h00;
  logic [7:0] ext1 = 8'h00;
  logic [7:0] drv1 = 8'h00;
  logic slow = 1'b0;
  logic [7:0] pin0, pin1, req0, req1, a, b, sel, en, e;
  pad_ctrl_s pad;
  logic clr = 1'b0;
  logic [7:0] seen0 = 8'h00;
  logic [7:0] seen1 = 8'h00;
  logic [7:0] ra [3] = '{OFF_PORT1_DIR, OFF_PORT0_EDGE, OFF_PORT1_EDGE};
  int pcnt = 0;
  int seed = 40345;
  int fail_count = 0;
  int tests_run = 0;
  int i, p;

  // ----------------------------------------------------------------
  // Clock, design and pin model
  // ----------------------------------------------------------------
  initial begin
    forever #2.5 clk = ~clk;
  end

  gpio_direction_edge_select uut (.CLK_SYS(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PORT0_PIN_IN(pin0),
    .PORT1_PIN_IN(pin1), .PORT1_PAD(pad), .PORT0_IRQ_REQ(req0), .PORT1_IRQ_REQ(req1),
    .IRQ(irq));

  pin_drive pins (.clk(clk), .slow(slow), .ext0(ext0), .ext1(ext1), .drv1(drv1), .pad(pad),
    .pin0(pin0), .pin1(pin1));

  // Collect request pulses and count high cycles of every request bit
  always @(posedge clk) begin
    if (clr) begin
      seen0 <= 8'h00;
      seen1 <= 8'h00;
      pcnt <= 0;
    end else begin
      seen0 <= seen0 | req0;
      seen1 <= seen1 | req1;
      pcnt <= pcnt + $countones({req0, req1});
    end
  end

  // ----------------------------------------------------------------
  // Bus tasks and checking
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Address and data offered together; each released when taken
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    logic pa, pw, ha, hw, hb;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      @(negedge clk);
      ha = pa && awready;
      hw = pw && wready;
      @(posedge clk);
      if (ha) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (hw) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do begin
      @(negedge clk);
      hb = bvalid;
      rsp = bresp;
      @(posedge clk);
    end while (!hb);
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] dt);
    logic hr;
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge clk);
      hr = arready;
      @(posedge clk);
    end while (!hr);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      hr = rvalid;
      dt = rdata;
      rsp = rresp;
      @(posedge clk);
    end while (!hr);
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Requests expected from a pin change a to b under edge select and enable
  function automatic logic [7:0] exp_edge(input logic [7:0] fa, fb, fs, fe);
    return ((~fa & fb & ~fs) | (fa & ~fb & fs)) & fe;
  endfunction : exp_edge

  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // Watchdog against a hung handshake
  initial begin
    #100000;
    fail_count++;
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pad reset", {8'h00, pad}, 32'h0);
    for (i = 0; i < 3; i++) begin
      rd(ra[i], d);
      chk("reg reset", d, 32'h0);
    end
    // Random data, upper bits included, must read back as the low byte only
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      wr(ra[i % 3], v);
      chk("write resp", rsp, RESP_OKAY);
      rd(ra[i % 3], d);
      chk("upper bits", d, {24'h0, v[7:0]});
      chk("read resp", rsp, RESP_OKAY);
    end
    drv1 <= 8'hff;
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      if (i == 0) v[31:24] = 8'hff;
      ext0 <= v[7:0];
      ext1 <= v[15:8];
      wr(OFF_PORT1_OUT, {24'h0, v[23:16]});
      wr(OFF_PORT1_DIR, {24'h0, v[31:24]});
      chk("direction", pad.out_en, v[31:24]);
      chk("out value", pad.out_val, v[31:24] & v[23:16]);
      chk("pull", pad.pull_en, ~v[31:24] & v[23:16]);
      rd(OFF_PIN_LEVEL, d);
      chk("pins", d, {16'h0, (v[31:24] & v[23:16]) | (~v[31:24] & v[15:8]), v[7:0]});
    end
    // Released pins: driven bits show the output value, pulled bits read high
    drv1 <= 8'h00;
    wr(OFF_PORT1_DIR, 32'h0000000f);
    rd(OFF_PIN_LEVEL, d);
    chk("pulls", d[15:8] & (8'h0f | v[23:16]), v[23:16]);
    drv1 <= 8'hff;
    wr(OFF_PORT1_DIR, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0000ffff);
    // Edge select corners in passes 0, 1 and 7, random between; enable all ones in passes 0 to 3 and 7, random in 4 to 6
    for (i = 0; i < 8; i++) begin
      p = i % 2;
      v = $random(seed);
      a = v[7:0];
      b = v[15:8];
      sel = (i == 0 || i == 7) ? 8'h00 : (i == 1) ? 8'hff : v[23:16];
      en = (i < 4 || i == 7) ? 8'hff : v[31:24];
      if (i == 7) a = 8'h00;
      if (i == 7) b = 8'hff;
      slow <= i[1];
      wr(p ? OFF_PORT1_EDGE : OFF_PORT0_EDGE, {24'h0, sel});
      wr(p ? OFF_PORT1_IRQEN : OFF_PORT0_IRQEN, {24'h0, en});
      if (p) ext1 <= a; else ext0 <= a;
      repeat (8) @(posedge clk);
      wr(OFF_IRQ_STATUS, 32'h0000ffff);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      if (p) ext1 <= b; else ext0 <= b;
      repeat (8) @(posedge clk);
      e = exp_edge(a, b, sel, en);
      chk("requests", p ? seen1 : seen0, e);
      chk("other port", p ? seen0 : seen1, 32'h0);
      chk("pulse count", pcnt, $countones(e));
      rd(OFF_IRQ_STATUS, d);
      chk("status", d, p ? {16'h0, e, 8'h00} : {24'h0, e});
      chk("irq", irq, e != 8'h00);
    end
    wr(OFF_IRQ_MASK, 32'h0);
    chk("irq masked", irq, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0000ff00);
    chk("irq unmasked", irq, 32'h1);
    wr(OFF_IRQ_STATUS, 32'h0000ff00);
    chk("irq cleared", irq, 32'h0);
    rd(8'h40, d);
    chk("unmapped read", rsp, RESP_SLVERR);
    wr(8'h44, 32'h1);
    chk("unmapped write", rsp, RESP_SLVERR);
    // Second reset in mid-run: direction and both edge registers must clear again
    for (i = 0; i < 3; i++) begin
      wr(ra[i], 32'h000000ff);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pad reset again", {8'h00, pad}, 32'h0);
    for (i = 0; i < 3; i++) begin
      rd(ra[i], d);
      chk("reg reset again", d, 32'h0);
    end
    test_done();
  end
endmodule : tb

// File: hw/edge_detect.sv
// Per-pin selectable edge detector producing one-cycle requests.
// Assumes synchronised pin levels on the same clock.
`timescale 1ns/1ps
module edge_detect #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] level,
  input wire logic [WIDTH-1:0] falling_sel,
  input wire logic [WIDTH-1:0] enable,
  output logic [WIDTH-1:0] req
);
  import gpio_des_pkg::*;

  logic [WIDTH-1:0] prev_reg;
  logic [WIDTH-1:0] rise_w;
  logic [WIDTH-1:0] fall_w;

  // ----------------------------------------------------------------
  // Edge selection: zero picks rising, one picks falling
  // ----------------------------------------------------------------
  assign rise_w = level & ~prev_reg;
  assign fall_w = ~level & prev_reg;
  assign req = enable & ((rise_w & ~falling_sel) | (fall_w & falling_sel));

  // Previous level for edge comparison
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= level;
    end
  end

  // Refuse a width that leaves no pins to watch
  if (WIDTH < 1) begin : g_width_check
    $error("edge_detect needs a WIDTH of at least one");
  end
endmodule : edge_detect

// File: hw/gpio_direction_edge_select.sv
// GPIO port 1 direction control and edge-select interrupts for ports 0 and 1.
// Assumes an AXI4-Lite master on CLK_SYS and pads that resolve out/oe/pull.
//
// Function
// - direction bit one makes pin an output
// - output pin drives its port output bit
// - direction bit zero leaves pin an input
// - input pin with output bit one: pull on
// - input pin with output bit zero: high-Z
// - each pin follows only its own bit
// - direction and edge registers reset to zero
// - upper eight bits read zero, writes ignored
// - per-port edge register, bit n for irq n
// - edge bit zero triggers on rising edge
// - edge bit one triggers on falling edge
// - enable bit one enables, zero disables interrupt
`timescale 1ns/1ps
module gpio_direction_edge_select (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [7:0] PORT0_PIN_IN,
  input wire logic [7:0] PORT1_PIN_IN,
  output gpio_des_pkg::pad_ctrl_s PORT1_PAD,
  output logic [7:0] PORT0_IRQ_REQ,
  output logic [7:0] PORT1_IRQ_REQ,
  output logic IRQ
);
  import gpio_des_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // Assert asynchronously, release through two flops
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_n = rst_sync_reg;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [7:0] port_output_value_reg;
  logic [7:0] port1_pin_direction_reg;
  logic [7:0] port0_irq_edge_select_reg;
  logic [7:0] port1_irq_edge_select_reg;
  logic [7:0] port0_irq_enable_reg;
  logic [7:0] port1_irq_enable_reg;
  logic [15:0] irq_status_reg;
  logic [15:0] irq_mask_reg;

  // ----------------------------------------------------------------
  // AXI write channel
  // ----------------------------------------------------------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_lane0;
  logic wr_lane1;
  logic wr_hit;
  logic [31:0] wr_val;

  assign S_AXI_AWREADY = !aw_held_reg && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held_reg && !S_AXI_BVALID;
  assign wr_fire = aw_held_reg && w_held_reg;
  assign wr_lane0 = wr_fire && w_strb_reg[0];
  assign wr_lane1 = wr_fire && w_strb_reg[1];
  assign wr_val = w_data_reg;

  // Decode a byte address to a mapped register
  function automatic logic addr_mapped(input logic [7:0] a);
    return a == OFF_PORT1_OUT || a == OFF_PORT1_DIR || a == OFF_PORT0_EDGE
      || a == OFF_PORT1_EDGE || a == OFF_PORT0_IRQEN || a == OFF_PORT1_IRQEN
      || a == OFF_IRQ_STATUS || a == OFF_IRQ_MASK || a == OFF_PIN_LEVEL;
  endfunction : addr_mapped

  assign wr_hit = addr_mapped(aw_addr_reg);

  // Hold address and data until both are present, then respond
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_reg <= 1'b1;
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register writes; byte lane 0 holds data, the mask also uses lane 1
  // ----------------------------------------------------------------
  logic wr_out;
  logic wr_dir;
  logic wr_edge0;
  logic wr_edge1;
  logic wr_en0;
  logic wr_en1;
  logic wr_mask;

  assign wr_out = wr_lane0 && aw_addr_reg == OFF_PORT1_OUT;
  assign wr_dir = wr_lane0 && aw_addr_reg == OFF_PORT1_DIR;
  assign wr_edge0 = wr_lane0 && aw_addr_reg == OFF_PORT0_EDGE;
  assign wr_edge1 = wr_lane0 && aw_addr_reg == OFF_PORT1_EDGE;
  assign wr_en0 = wr_lane0 && aw_addr_reg == OFF_PORT0_IRQEN;
  assign wr_en1 = wr_lane0 && aw_addr_reg == OFF_PORT1_IRQEN;
  assign wr_mask = wr_fire && aw_addr_reg == OFF_IRQ_MASK;

  // Bits 15:8 of the byte registers are never stored, so they read zero and ignore writes
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      port_output_value_reg <= RST_BYTE;
      port1_pin_direction_reg <= RST_BYTE;
      port0_irq_edge_select_reg <= RST_BYTE;
      port1_irq_edge_select_reg <= RST_BYTE;
      port0_irq_enable_reg <= RST_BYTE;
      port1_irq_enable_reg <= RST_BYTE;
      irq_mask_reg <= RST_MASK;
    end else begin
      if (wr_out) port_output_value_reg <= wr_val[7:0];
      if (wr_dir) port1_pin_direction_reg <= wr_val[7:0];
      if (wr_edge0) port0_irq_edge_select_reg <= wr_val[7:0];
      if (wr_edge1) port1_irq_edge_select_reg <= wr_val[7:0];
      if (wr_en0) port0_irq_enable_reg <= wr_val[7:0];
      if (wr_en1) port1_irq_enable_reg <= wr_val[7:0];
      if (wr_mask) begin
        if (w_strb_reg[0]) irq_mask_reg[7:0] <= wr_val[7:0];
        if (w_strb_reg[1]) irq_mask_reg[15:8] <= wr_val[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Pad control of port 1, bit by bit
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_pad
      assign PORT1_PAD.out_en[gi] = port1_pin_direction_reg[gi];
      assign PORT1_PAD.out_val[gi] = port1_pin_direction_reg[gi]
        & port_output_value_reg[gi];
      assign PORT1_PAD.pull_en[gi] = ~port1_pin_direction_reg[gi]
        & port_output_value_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detectors
  // ----------------------------------------------------------------
  logic [7:0] port0_level;
  logic [7:0] port1_level;

  pin_sync #(.WIDTH(PORT_W)) u_sync0 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .async_in(PORT0_PIN_IN),
    .sync_out(port0_level)
  );

  pin_sync #(.WIDTH(PORT_W)) u_sync1 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .async_in(PORT1_PIN_IN),
    .sync_out(port1_level)
  );

  edge_detect #(.WIDTH(PORT_W)) u_edge0 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .level(port0_level),
    .falling_sel(port0_irq_edge_select_reg),
    .enable(port0_irq_enable_reg),
    .req(PORT0_IRQ_REQ)
  );

  edge_detect #(.WIDTH(PORT_W)) u_edge1 (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .level(port1_level),
    .falling_sel(port1_irq_edge_select_reg),
    .enable(port1_irq_enable_reg),
    .req(PORT1_IRQ_REQ)
  );

  // ----------------------------------------------------------------
  // Sticky status, write one to clear; a new event wins over clear
  // ----------------------------------------------------------------
  logic [15:0] events;
  logic [15:0] clr_bits;
  logic wr_status;

  assign events = {PORT1_IRQ_REQ, PORT0_IRQ_REQ};
  assign wr_status = wr_fire && aw_addr_reg == OFF_IRQ_STATUS;
  assign clr_bits = wr_status ? (wr_val[15:0] & {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}})
    : 16'h0000;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= RST_MASK;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clr_bits) | events;
    end
  end

  assign IRQ = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // AXI read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [7:0] ar_addr;

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign ar_addr = {S_AXI_ARADDR[7:2], 2'b00};
  assign rd_mux =
    ar_addr == OFF_PORT1_OUT ? {24'h000000, port_output_value_reg} :
    ar_addr == OFF_PORT1_DIR ? {24'h000000, port1_pin_direction_reg} :
    ar_addr == OFF_PORT0_EDGE ? {24'h000000, port0_irq_edge_select_reg} :
    ar_addr == OFF_PORT1_EDGE ? {24'h000000, port1_irq_edge_select_reg} :
    ar_addr == OFF_PORT0_IRQEN ? {24'h000000, port0_irq_enable_reg} :
    ar_addr == OFF_PORT1_IRQEN ? {24'h000000, port1_irq_enable_reg} :
    ar_addr == OFF_IRQ_STATUS ? {16'h0000, irq_status_reg} :
    ar_addr == OFF_IRQ_MASK ? {16'h0000, irq_mask_reg} :
    ar_addr == OFF_PIN_LEVEL ? {16'h0000, port1_level, port0_level} :
    32'h0000_0000;

  // Capture read data on address handshake
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= rd_mux;
      S_AXI_RRESP <= addr_mapped(ar_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!rst_n);

  a_dir_out_en: assert property (PORT1_PAD.out_en == port1_pin_direction_reg)
    else $error("output enable differs from direction");
  a_out_drive: assert property (wr_out && wr_val[0] ##1 port1_pin_direction_reg[0]
    |-> PORT1_PAD.out_val[0])
    else $error("output pin not driving written value");
  a_input_free: assert property (!port1_pin_direction_reg[3] |-> !PORT1_PAD.out_en[3])
    else $error("input pin is driven");
  a_pull_on: assert property (!port1_pin_direction_reg[5] && port_output_value_reg[5]
    |-> PORT1_PAD.pull_en[5])
    else $error("pull not enabled on input pin");
  a_pull_off: assert property (PORT1_PAD.pull_en[2] |-> port_output_value_reg[2]
    && !port1_pin_direction_reg[2])
    else $error("pull enabled without cause");
  a_pin_alone: assert property (wr_dir |=> PORT1_PAD.out_en == $past(wr_val[7:0]))
    else $error("direction write not seen on each pin");
  a_upper_zero: assert property (S_AXI_RVALID && S_AXI_RDATA[7:0] != 8'h00
    && ($past(ar_addr) == OFF_PORT1_DIR) |-> S_AXI_RDATA[31:8] == 24'h000000)
    else $error("upper bits of direction read nonzero");
  a_rise_trig: assert property (port0_irq_enable_reg[0] && !port0_irq_edge_select_reg[0]
    && $rose(port0_level[0]) |-> PORT0_IRQ_REQ[0])
    else $error("rising edge missed");
  a_fall_trig: assert property (port1_irq_enable_reg[1] && port1_irq_edge_select_reg[1]
    && $fell(port1_level[1]) |-> PORT1_IRQ_REQ[1])
    else $error("falling edge missed");
  a_en_gate: assert property (!port0_irq_enable_reg[4] |-> !PORT0_IRQ_REQ[4])
    else $error("disabled interrupt requested");
  a_req_pulse: assert property (PORT1_IRQ_REQ[6] |=> !PORT1_IRQ_REQ[6])
    else $error("request wider than one cycle");
  a_status_sticky: assert property (PORT0_IRQ_REQ[7] |=> irq_status_reg[7][*2])
    else $error("event not held in status");

  c_write_done: cover property (wr_fire ##[1:4] S_AXI_BVALID && S_AXI_BREADY);
  c_read_done: cover property (S_AXI_RVALID && S_AXI_RREADY);
  c_irq_raise: cover property ($rose(IRQ));
  c_fall_event: cover property (|(PORT1_IRQ_REQ & port1_irq_edge_select_reg));
endmodule : gpio_direction_edge_select

// File: hw/pin_sync.sv
// Two-flop synchroniser for a bus of asynchronous pin levels.
// Assumes inputs come from pins outside the CLK_SYS domain.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  import gpio_des_pkg::*;

  logic [WIDTH-1:0] meta_reg;

  // ----------------------------------------------------------------
  // Two stages; only the second stage reads the first
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

  // Refuse a width that leaves no pins to synchronise
  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs a WIDTH of at least one");
  end
endmodule : pin_sync

// File: inc/gpio_des_pkg.sv
// Package for the GPIO direction and edge-select block.
// Assumes a 32-bit AXI4-Lite register bus; offsets are byte addresses.
package gpio_des_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PORT1_OUT = 8'h00;
  localparam logic [7:0] OFF_PORT1_DIR = 8'h04;
  localparam logic [7:0] OFF_PORT0_EDGE = 8'h08;
  localparam logic [7:0] OFF_PORT1_EDGE = 8'h0c;
  localparam logic [7:0] OFF_PORT0_IRQEN = 8'h10;
  localparam logic [7:0] OFF_PORT1_IRQEN = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1c;
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h20;

  // ----------------------------------------------------------------
  // Reset values and field layout
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_MASK = 16'h0000;
  localparam int PORT_W = 8;
  localparam int SYNC_STAGES = 2;
  // Status and mask: bits 7:0 port 0 events, bits 15:8 port 1 events
  localparam int ST_PORT1_LSB = 8;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Pad control of one port
  typedef struct packed {
    logic [7:0] out_val;
    logic [7:0] out_en;
    logic [7:0] pull_en;
  } pad_ctrl_s;

endpackage : gpio_des_pkg
